// ===== core/etsr_readout.sv
// Third and fourth capture sample result registers behind an APB slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "etsr_params.svh"

module etsr_readout (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic unit_index_in,
  input wire etsr_pkg::etsr_cap_s cap_in,
  input wire etsr_pkg::etsr_apb_req_s apb_in,
  output etsr_pkg::etsr_apb_rsp_s apb_out
);
  import etsr_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Returns {hit, fourth, field}; field 0 nanos, 1 secs, 2 phase
  function automatic logic [3:0] reg_sel(input logic [31:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    unique case (addr)
      `ETSR_OFF_THIRD_NS: sel = 4'h8;
      `ETSR_OFF_THIRD_SECS: sel = 4'h9;
      `ETSR_OFF_THIRD_PHASE: sel = 4'ha;
      `ETSR_OFF_FOURTH_NS: sel = 4'hc;
      `ETSR_OFF_FOURTH_SECS: sel = 4'hd;
      `ETSR_OFF_FOURTH_PHASE: sel = 4'he;
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction : reg_sel

  function automatic logic [2:0] slot_code(input logic [2:0] slot);
    logic [2:0] code;
    code = `ETSR_RST_CODE;
    unique case (slot)
      3'h0: code = 3'h0;
      3'h1: code = 3'h1;
      3'h2: code = 3'h2;
      3'h3: code = 3'h3;
      3'h4: code = 3'h4;
      default: code = `ETSR_RST_CODE;
    endcase
    return code;
  endfunction : slot_code

  function automatic logic [31:0] read_word(input etsr_sample_s s, input logic [1:0] field);
    logic [31:0] word;
    word = `ETSR_RST_WORD;
    unique case (field)
      2'h0: begin
        word[`ETSR_NS_MSB:0] = s.nanos;
        word[`ETSR_POL_BIT] = s.pol;
      end
      2'h1: word = s.secs;
      2'h2: word[`ETSR_CODE_MSB:0] = s.code;
      default: word = `ETSR_RST_WORD;
    endcase
    return word;
  endfunction : read_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  etsr_state_s st;
  etsr_state_s next_st;
  logic [3:0] sel;
  logic setup;
  logic cap_ok;

  assign sel = reg_sel(apb_in.paddr);
  assign setup = apb_in.psel && !apb_in.penable;
  assign cap_ok = cap_in.valid && (cap_in.phase_slot < 3'(`ETSR_SLOT_COUNT));
  assign apb_out = st.rsp;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    // Captures with a slot outside the period are dropped
    if (cap_ok) begin
      next_st.mem[cap_in.unit][cap_in.fourth].pol = cap_in.rising;
      next_st.mem[cap_in.unit][cap_in.fourth].nanos = cap_in.nanos;
      next_st.mem[cap_in.unit][cap_in.fourth].secs = cap_in.secs;
      next_st.mem[cap_in.unit][cap_in.fourth].code = slot_code(cap_in.phase_slot);
    end
    // Answer in the first access cycle; writes store nothing
    if (setup) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.prdata = `ETSR_RST_WORD;
      if (!sel[3]) begin
        next_st.rsp.pslverr = 1'b1;
      end else if (!apb_in.pwrite) begin
        next_st.rsp.prdata = read_word(st.mem[unit_index_in][sel[2]], sel[1:0]);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic rd_setup;
  assign rd_setup = setup && !apb_in.pwrite;

  property p_unit_view;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'h9) |=> apb_out.prdata == $past(st.mem[unit_index_in][0].secs);
  endproperty
  a_unit_view: assert property (p_unit_view) else $error("seconds not from selected unit");

  property p_third_pol;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'h8) |=> apb_out.prdata[30] == $past(st.mem[unit_index_in][0].pol);
  endproperty
  a_third_pol: assert property (p_third_pol) else $error("third polarity bit wrong");

  property p_rising;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && !cap_in.unit && !cap_in.fourth) |=> st.mem[0][0].pol == $past(cap_in.rising);
  endproperty
  a_rising: assert property (p_rising) else $error("polarity encoding wrong");

  property p_third_ns;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'h8) |=> !apb_out.prdata[31] && apb_out.pready
      && apb_out.prdata[29:0] == $past(st.mem[unit_index_in][0].nanos);
  endproperty
  a_third_ns: assert property (p_third_ns) else $error("third nanoseconds wrong");

  property p_third_secs;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.unit && !cap_in.fourth) |=> st.mem[1][0].secs == $past(cap_in.secs);
  endproperty
  a_third_secs: assert property (p_third_secs) else $error("third seconds not captured");

  property p_third_phase;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'ha) |=> apb_out.prdata[31:3] == 29'h0 && !apb_out.pslverr;
  endproperty
  a_third_phase: assert property (p_third_phase) else $error("phase reserved bits set");

  property p_code_low;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && !cap_in.unit && !cap_in.fourth && cap_in.phase_slot == 3'h1)
      |=> st.mem[0][0].code == 3'h1;
  endproperty
  a_code_low: assert property (p_code_low) else $error("second slot code wrong");

  property p_code_high;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.fourth && cap_in.phase_slot == 3'h4) |=> st.mem[$past(cap_in.unit)][1].code == 3'h4;
  endproperty
  a_code_high: assert property (p_code_high) else $error("fifth slot code wrong");

  property p_code_legal;
    @(posedge clk_in) disable iff (rst_in)
    cap_in.valid && cap_in.phase_slot > 3'h4 |=> $stable(st.mem);
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("reserved code stored");

  property p_fourth_pol;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'hc) |=> apb_out.prdata[30] == $past(st.mem[unit_index_in][1].pol);
  endproperty
  a_fourth_pol: assert property (p_fourth_pol) else $error("fourth polarity bit wrong");

  property p_fourth_ns;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'hc) |=> !apb_out.prdata[31]
      && apb_out.prdata[29:0] == $past(st.mem[unit_index_in][1].nanos);
  endproperty
  a_fourth_ns: assert property (p_fourth_ns) else $error("fourth nanoseconds wrong");

  property p_fourth_secs;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'hd) |=> apb_out.prdata == $past(st.mem[unit_index_in][1].secs);
  endproperty
  a_fourth_secs: assert property (p_fourth_secs) else $error("fourth seconds wrong");

  property p_fourth_phase;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'he) |=> apb_out.prdata == {29'h0, $past(st.mem[unit_index_in][1].code)};
  endproperty
  a_fourth_phase: assert property (p_fourth_phase) else $error("fourth phase word wrong");

  property p_code_mid;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.unit && !cap_in.fourth && cap_in.phase_slot == 3'h2)
      |=> st.mem[1][0].code == 3'h2;
  endproperty
  a_code_mid: assert property (p_code_mid) else $error("third slot code not 010");

  property p_write_inert;
    @(posedge clk_in) disable iff (rst_in)
    (setup && apb_in.pwrite && !cap_in.valid) |=> $stable(st.mem) && apb_out.prdata == 32'h0;
  endproperty
  a_write_inert: assert property (p_write_inert) else $error("write changed a sample");

  // ----------------------------------------------------------------
  // Bus response assertions
  // ----------------------------------------------------------------
  property p_ready_after_setup;
    @(posedge clk_in) disable iff (rst_in)
    setup |=> apb_out.pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");

  property p_ready_single;
    @(posedge clk_in) disable iff (rst_in)
    apb_out.pready |=> !apb_out.pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready longer than one cycle");

  property p_ready_cause;
    @(posedge clk_in) disable iff (rst_in)
    apb_out.pready |-> $past(setup);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without a setup");

  property p_err_with_ready;
    @(posedge clk_in) disable iff (rst_in)
    apb_out.pslverr |-> apb_out.pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_unmapped;
    @(posedge clk_in) disable iff (rst_in)
    (setup && !sel[3]) |=> apb_out.pslverr && apb_out.prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_mapped_ok;
    @(posedge clk_in) disable iff (rst_in)
    (setup && sel[3]) |=> !apb_out.pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged as error");

  property p_data_hold;
    @(posedge clk_in) disable iff (rst_in)
    !setup |=> $stable(apb_out.prdata);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data changed outside setup");

  property p_reset_clear;
    @(posedge clk_in)
    rst_in |=> st.mem == '0 && apb_out == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not zero after reset");

  // ----------------------------------------------------------------
  // Readback assertions
  // ----------------------------------------------------------------
  property p_third_code_read;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'ha) |=> apb_out.prdata[2:0] == $past(st.mem[unit_index_in][0].code);
  endproperty
  a_third_code_read: assert property (p_third_code_read) else $error("third slot code read wrong");

  property p_view_unit0;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'h9 && !unit_index_in) |=> apb_out.prdata == $past(st.mem[0][0].secs);
  endproperty
  a_view_unit0: assert property (p_view_unit0) else $error("unit zero view wrong");

  property p_view_unit1;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'hd && unit_index_in) |=> apb_out.prdata == $past(st.mem[1][1].secs);
  endproperty
  a_view_unit1: assert property (p_view_unit1) else $error("unit one view wrong");

  property p_pol_read_unit1;
    @(posedge clk_in) disable iff (rst_in)
    (rd_setup && sel == 4'h8 && unit_index_in) |=> apb_out.prdata[30] == $past(st.mem[1][0].pol);
  endproperty
  a_pol_read_unit1: assert property (p_pol_read_unit1) else $error("unit one polarity read wrong");

  // ----------------------------------------------------------------
  // Capture coding assertions
  // ----------------------------------------------------------------
  property p_code_first;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.phase_slot == 3'h0) |=> st.mem[$past(cap_in.unit)][$past(cap_in.fourth)].code == 3'h0;
  endproperty
  a_code_first: assert property (p_code_first) else $error("first slot code wrong");

  property p_code_fourth_slot;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.phase_slot == 3'h3) |=> st.mem[$past(cap_in.unit)][$past(cap_in.fourth)].code == 3'h3;
  endproperty
  a_code_fourth_slot: assert property (p_code_fourth_slot) else $error("fourth slot code wrong");

  property p_fourth_pol_store;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.fourth) |=> st.mem[$past(cap_in.unit)][1].pol == $past(cap_in.rising);
  endproperty
  a_fourth_pol_store: assert property (p_fourth_pol_store) else $error("fourth polarity not stored");

  property p_code_mid_fourth;
    @(posedge clk_in) disable iff (rst_in)
    (cap_ok && cap_in.fourth && cap_in.phase_slot == 3'h2) |=> st.mem[$past(cap_in.unit)][1].code == 3'h2;
  endproperty
  a_code_mid_fourth: assert property (p_code_mid_fourth) else $error("fourth sample 16ns code wrong");

  // ----------------------------------------------------------------
  // Per slot bookkeeping assertions
  // ----------------------------------------------------------------
  for (genvar gu = 0; gu < 2; gu++) begin : g_unit
    for (genvar gf = 0; gf < 2; gf++) begin : g_slot
      property p_slot_store;
        @(posedge clk_in) disable iff (rst_in)
        (cap_ok && cap_in.unit == 1'(gu) && cap_in.fourth == 1'(gf))
          |=> st.mem[gu][gf].pol == $past(cap_in.rising) && st.mem[gu][gf].nanos == $past(cap_in.nanos)
          && st.mem[gu][gf].secs == $past(cap_in.secs);
      endproperty
      a_slot_store: assert property (p_slot_store) else $error("capture not stored in its slot");

      property p_slot_keep;
        @(posedge clk_in) disable iff (rst_in)
        !(cap_ok && cap_in.unit == 1'(gu) && cap_in.fourth == 1'(gf)) |=> $stable(st.mem[gu][gf]);
      endproperty
      a_slot_keep: assert property (p_slot_keep) else $error("slot changed without its capture");
    end
  end

endmodule : etsr_readout

// ===== core/etsr_params.svh
// Offsets, field positions, reset values and timing of the sample readout
`ifndef ETSR_PARAMS_SVH
`define ETSR_PARAMS_SVH

// Register byte addresses
`define ETSR_OFF_THIRD_NS 32'h0000056c
`define ETSR_OFF_THIRD_SECS 32'h00000570
`define ETSR_OFF_THIRD_PHASE 32'h00000574
`define ETSR_OFF_FOURTH_NS 32'h00000578
`define ETSR_OFF_FOURTH_SECS 32'h0000057c
`define ETSR_OFF_FOURTH_PHASE 32'h00000580

// Field positions
`define ETSR_POL_BIT 30
`define ETSR_NS_MSB 29
`define ETSR_CODE_MSB 2

// Reset values
`define ETSR_RST_WORD 32'h00000000
`define ETSR_RST_CODE 3'h0

// Phase slot timing
`define ETSR_SLOT_NS 8
`define ETSR_PERIOD_NS 40
`define ETSR_SLOT_COUNT ((`ETSR_PERIOD_NS) / (`ETSR_SLOT_NS))

`endif

// ===== core/etsr_pkg.sv
// Types of the event timestamp sample readout
package etsr_pkg;

  typedef struct packed {
    logic pol;
    logic [29:0] nanos;
    logic [31:0] secs;
    logic [2:0] code;
  } etsr_sample_s;

  typedef struct packed {
    logic valid;
    logic unit;
    logic fourth;
    logic rising;
    logic [29:0] nanos;
    logic [31:0] secs;
    logic [2:0] phase_slot;
  } etsr_cap_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } etsr_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } etsr_apb_rsp_s;

  typedef struct packed {
    etsr_sample_s [1:0][1:0] mem;
    etsr_apb_rsp_s rsp;
  } etsr_state_s;

endpackage : etsr_pkg

// ===== bench/test_event_timestamp_sample_readout.sv
// Self-checking bench of the event timestamp sample readout
`timescale 1ns/10ps
`include "etsr_params.svh"

module test_event_timestamp_sample_readout;
  import etsr_pkg::*;
  logic clk_in;
  logic rst_in;
  logic unit_index_in;
  etsr_cap_s cap_in;
  etsr_apb_req_s apb_in;
  etsr_apb_rsp_s apb_out;
  int n_errors;
  int total_checks;
  int k;
  logic [31:0] rd;
  logic [31:0] ra;
  logic [31:0] rb;
  logic err;
  logic [31:0] m_word [2][2][3];
  localparam logic [31:0] OFFS [6] = '{`ETSR_OFF_THIRD_NS, `ETSR_OFF_THIRD_SECS, `ETSR_OFF_THIRD_PHASE,
    `ETSR_OFF_FOURTH_NS, `ETSR_OFF_FOURTH_SECS, `ETSR_OFF_FOURTH_PHASE};
  localparam logic [31:0] BAD [3] = '{32'h00000584, 32'h00000568, 32'h0001056c};

  etsr_readout i_dut (.clk_in(clk_in), .rst_in(rst_in), .unit_index_in(unit_index_in), .cap_in(cap_in),
    .apb_in(apb_in), .apb_out(apb_out));

  // ----------------------------------------
  // Compare tasks
  // ----------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  // ----------------------------------------
  // Bus and capture drivers
  // ----------------------------------------
  task automatic apb_xfer(input logic wr, input logic u, input logic [31:0] addr, input logic [31:0] wd,
      output logic [31:0] rdata, output logic slverr);
    int n;
    @(posedge clk_in);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    unit_index_in <= u;
    @(posedge clk_in);
    apb_in.penable <= 1'b1;
    chk_flag("pready before access", 1'b0, apb_out.pready);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (apb_out.pready !== 1'b1);
    rdata = apb_out.prdata;
    slverr = apb_out.pslverr;
    chk_word("access cycles", 32'd1, 32'(n));
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask : apb_xfer

  task automatic capture(input logic u, input logic f, input logic r, input logic [29:0] ns,
      input logic [31:0] s, input logic [2:0] ps);
    @(posedge clk_in);
    cap_in <= '{valid: 1'b1, unit: u, fourth: f, rising: r, nanos: ns, secs: s, phase_slot: ps};
    @(posedge clk_in);
    cap_in.valid <= 1'b0;
    // Slots 5..7 are dropped; slot n is coded as n
    if (ps <= 3'd4) begin
      m_word[u][f][0] = {1'b0, r, ns};
      m_word[u][f][1] = s;
      m_word[u][f][2] = {29'h0, ps};
    end
  endtask : capture

  task automatic check_all();
    logic [31:0] d;
    logic e;
    for (int u = 0; u < 2; u++) begin
      for (int i = 0; i < 6; i++) begin
        apb_xfer(1'b0, u[0], OFFS[i], 32'h0, d, e);
        chk_word("prdata", m_word[u][i / 3][i % 3], d);
        chk_flag("pslverr", 1'b0, e);
      end
    end
  endtask : check_all

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst_in = 1'b1;
    unit_index_in = 1'b0;
    cap_in = '0;
    apb_in = '0;
    m_word = '{default: 32'h0};
    void'($urandom(32'h77f5));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    check_all();
    $display("test reset_values done");
    for (k = 0; k < 32; k++) begin
      ra = $urandom;
      rb = $urandom;
      capture(ra[31], k[3], ra[30], ra[29:0], rb, k[2:0]);
      if (k % 4 == 3) check_all();
    end
    capture(1'b1, 1'b0, 1'b1, 30'h3fffffff, 32'hffffffff, 3'd4);
    capture(1'b0, 1'b1, 1'b0, 30'h3fffffff, 32'hffffffff, 3'd3);
    check_all();
    capture(1'b1, 1'b0, 1'b0, 30'h15555555, 32'h0000a5a5, 3'd2);
    capture(1'b0, 1'b0, 1'b1, 30'h2aaaaaaa, 32'h5a5a0000, 3'd1);
    check_all();
    $display("test captures done");
    for (k = 0; k < 6; k++) begin
      apb_xfer(1'b1, k[0], OFFS[k], 32'hffffffff, rd, err);
      chk_flag("write pslverr", 1'b0, err);
      chk_word("write prdata", 32'h0, rd);
    end
    check_all();
    for (k = 0; k < 3; k++) begin
      apb_xfer(1'b0, 1'b0, BAD[k], 32'h0, rd, err);
      chk_flag("unmapped pslverr", 1'b1, err);
      chk_word("unmapped prdata", 32'h0, rd);
    end
    $display("test writes_unmapped done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    m_word = '{default: 32'h0};
    check_all();
    $display("test second_reset done");
    report_and_stop();
  end
endmodule : test_event_timestamp_sample_readout
